// ==== src/flash_guard_pkg.sv ====
// constants, field layouts and types for the flash access checker
// assumes a 14-bit flash byte address, lock byte stored as the last user byte
//
// Summary of operation
// - software write needs write enable; software page erase needs write and erase enables
// - last user byte is lock byte; its complement counts locked pages from page 0
// - lock byte page unlocked while lock byte is all ones, else locked
// - unlocked ordinary pages are open to debug port and all firmware
// - locked ordinary pages: debug refused, unlocked firmware faults, locked firmware allowed
// - lock page read or write while locked: debug refused, unlocked firmware faults
// - reading the lock byte follows the lock page permissions
// - with nothing locked debug may erase lock page; firmware erase of it faults
// - while locked only debug whole-device erase clears lock page; firmware faults
// - whole-device erase from debug port erases every page including lock page
// - once written the lock byte cannot be rewritten until whole-device erase
// - reserved area: debug refused, firmware from any page faults
// - firmware violation resets device and flash fault flag reads one afterwards
// - forbidden debug operations are ignored without any device reset
// - firmware lock byte write takes effect only after the next device reset
// - interrupts posted during flash write or erase are held until it finishes
// - program store control at index 0x8f, reset zero, bit1 erase, bit0 write
package flash_guard_pkg;
  localparam int ADDR_W = 14;
  localparam int PAGE_LSB = 9;
  localparam int PAGE_W = 5;
  localparam int IRQ_W = 8;
  localparam logic [ADDR_W-1:0] LOCK_ADDR = 14'h3dff;
  localparam logic [ADDR_W-1:0] RES_BASE = 14'h3e00;
  localparam logic [PAGE_W-1:0] LOCK_PAGE = 5'h1e;
  localparam logic [7:0] LOCK_ERASED = 8'hff;
  localparam logic [7:0] LOCK_SAFE = 8'h00;
  // register indexes; byte address is four times the index
  localparam logic [7:0] PSC_IDX = 8'h8f;
  localparam logic [7:0] CAUSE_IDX = 8'h90;
  localparam logic [7:0] LSTAT_IDX = 8'h91;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam int PSC_FWE_BIT = 0;
  localparam int PSC_FEE_BIT = 1;
  localparam int CAUSE_FAULT_BIT = 0;
  localparam int LSTAT_ANY_BIT = 8;
  localparam int LSTAT_WR_BIT = 9;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {op_read, op_write, op_erase, op_dev_erase} flash_op_type;
  typedef enum logic [1:0] {v_allow, v_refuse, v_fault} verdict_type;
endpackage : flash_guard_pkg

// ==== src/access_judge.sv ====
// combinational verdict for one flash request
// assumes inputs stable from the same clock domain
`timescale 1ns/1ps
module access_judge (
  input wire logic is_debug, // request comes from two-wire debug port
  input wire flash_guard_pkg::flash_op_type op, // requested operation
  input wire logic [flash_guard_pkg::ADDR_W-1:0] addr, // target byte address
  input wire logic [flash_guard_pkg::ADDR_W-1:0] exec_addr, // executing instruction address
  input wire logic [7:0] lock_byte, // latched lock byte
  input wire logic lock_written, // lock byte written since reset
  input wire logic flash_write_enable, // software write enable
  input wire logic flash_erase_enable, // software erase enable
  output flash_guard_pkg::verdict_type verdict // allow, refuse or fault
);
  import flash_guard_pkg::*;

  logic [7:0] lock_n;
  logic any_locked;
  logic [PAGE_W-1:0] page;
  logic [PAGE_W-1:0] exec_page;
  logic page_locked;
  logic exec_locked;
  verdict_type forbid;

  // page classes
  always_comb begin
    lock_n = ~lock_byte;
    any_locked = (lock_byte != LOCK_ERASED);
    page = addr[ADDR_W-1:PAGE_LSB];
    exec_page = exec_addr[ADDR_W-1:PAGE_LSB];
    page_locked = ({3'h0, page} < lock_n);
    exec_locked = ({3'h0, exec_page} < lock_n) || ((exec_page == LOCK_PAGE) && any_locked);
    forbid = is_debug ? v_refuse : v_fault;
  end

  // verdict priority
  always_comb begin
    verdict = v_allow;
    if (op == op_dev_erase) begin
      verdict = is_debug ? v_allow : v_fault;
    end else if (addr >= RES_BASE) begin
      verdict = forbid;
    end else if (page == LOCK_PAGE) begin
      if (op == op_erase) begin
        verdict = (is_debug && !any_locked) ? v_allow : forbid;
      end else if ((op == op_write) && (addr == LOCK_ADDR) && (lock_written || any_locked)) begin
        verdict = forbid;
      end else if (any_locked) begin
        verdict = (!is_debug && exec_locked) ? v_allow : forbid;
      end
    end else if (page_locked) begin
      verdict = (!is_debug && exec_locked) ? v_allow : forbid;
    end
    // software enables gate modification ahead of the security check
    if (!is_debug && (op == op_write) && !flash_write_enable) begin
      verdict = v_refuse;
    end
    if (!is_debug && (op == op_erase) && !(flash_write_enable && flash_erase_enable)) begin
      verdict = v_refuse;
    end
  end
endmodule : access_judge

// ==== src/irq_hold.sv ====
// holds posted interrupts while a flash write or erase runs
// assumes irq pulses and acknowledges on the system clock
`timescale 1ns/1ps
module irq_hold (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic flash_busy, // flash write or erase in progress
  input wire logic [flash_guard_pkg::IRQ_W-1:0] irq_in, // posted interrupt pulses
  input wire logic [flash_guard_pkg::IRQ_W-1:0] irq_ack, // cpu clears serviced lines
  output logic [flash_guard_pkg::IRQ_W-1:0] irq_out // pending lines shown to cpu
);
  import flash_guard_pkg::*;

  logic [IRQ_W-1:0] pending;
  logic [IRQ_W-1:0] next_pending;
  logic [IRQ_W-1:0] next_irq_out;

  // sticky pending, a new post wins over an acknowledge
  always_comb begin
    next_pending = (pending & ~irq_ack) | irq_in;
    next_irq_out = flash_busy ? '0 : next_pending;
  end

  // state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= '0;
      irq_out <= '0;
    end else begin
      pending <= next_pending;
      irq_out <= next_irq_out;
    end
  end
endmodule : irq_hold

// ==== src/flash_guard.sv ====
// flash security access checker with AHB-Lite register slave
// assumes one clock; por_n resets only the reset cause record,
// hresetn is the device reset that fault_reset_req asks for
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module flash_guard (
  input wire logic hclk, // system clock
  input wire logic hresetn, // device reset, async, active low
  input wire logic por_n, // power-on reset, async, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [7:0] lock_byte_in, // lock byte as stored in flash
  input wire logic [flash_guard_pkg::ADDR_W-1:0] exec_addr, // executing instruction address
  input wire logic cpu_req, // firmware flash request pulse
  input wire flash_guard_pkg::flash_op_type cpu_op, // firmware operation
  input wire logic [flash_guard_pkg::ADDR_W-1:0] cpu_addr, // firmware target
  output logic cpu_grant, // firmware request may proceed
  output logic cpu_refused, // firmware request dropped by enables
  input wire logic dbg_req, // debug port flash request pulse
  input wire flash_guard_pkg::flash_op_type dbg_op, // debug operation
  input wire logic [flash_guard_pkg::ADDR_W-1:0] dbg_addr, // debug target
  output logic dbg_grant, // debug request may proceed
  output logic dbg_ignored, // debug request silently dropped
  output logic fault_reset_req, // flash error device reset request
  input wire logic flash_busy, // flash write or erase running
  input wire logic [flash_guard_pkg::IRQ_W-1:0] irq_in, // interrupt posts
  input wire logic [flash_guard_pkg::IRQ_W-1:0] irq_ack, // interrupt acknowledges
  output logic [flash_guard_pkg::IRQ_W-1:0] irq_out // held interrupt lines
);
  import flash_guard_pkg::*;

  // register decode, used for both read and write
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:10] == 22'h0) && (a[9:2] == idx);
  endfunction : hit

  // bus state
  logic wr_pend;
  logic [31:0] wr_addr;
  logic next_wr_pend;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;

  // control and lock state
  logic flash_write_enable;
  logic flash_erase_enable;
  logic next_flash_write_enable;
  logic next_flash_erase_enable;
  logic [7:0] lock_byte;
  logic [7:0] next_lock_byte;
  logic load_pend;
  logic next_load_pend;
  logic lock_written;
  logic next_lock_written;

  // request outcome state
  logic next_cpu_grant;
  logic next_cpu_refused;
  logic next_dbg_grant;
  logic next_dbg_ignored;
  logic next_fault_reset_req;
  verdict_type cpu_verdict;
  verdict_type dbg_verdict;
  logic fault_now;

  // reset cause state, survives device reset
  logic fault_pending;
  logic next_fault_pending;
  logic load_prev;
  logic flash_fault_flag;
  logic next_flash_fault_flag;

  access_judge u_cpu_judge (
    .is_debug(1'b0),
    .op(cpu_op),
    .addr(cpu_addr),
    .exec_addr(exec_addr),
    .lock_byte(lock_byte),
    .lock_written(lock_written),
    .flash_write_enable(flash_write_enable),
    .flash_erase_enable(flash_erase_enable),
    .verdict(cpu_verdict)
  );

  access_judge u_dbg_judge (
    .is_debug(1'b1),
    .op(dbg_op),
    .addr(dbg_addr),
    .exec_addr(exec_addr),
    .lock_byte(lock_byte),
    .lock_written(lock_written),
    .flash_write_enable(flash_write_enable),
    .flash_erase_enable(flash_erase_enable),
    .verdict(dbg_verdict)
  );

  irq_hold u_irq_hold (
    .hclk(hclk),
    .hresetn(hresetn),
    .flash_busy(flash_busy),
    .irq_in(irq_in),
    .irq_ack(irq_ack),
    .irq_out(irq_out)
  );

  // ahb address phase capture and read data
  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = 32'h0;
    if (hsel && hready && (htrans == HTRANS_NONSEQ)) begin
      if (hwrite) begin
        next_wr_pend = 1'b1;
        next_wr_addr = haddr;
      end else if (hit(haddr, PSC_IDX)) begin
        next_hrdata[PSC_FWE_BIT] = flash_write_enable;
        next_hrdata[PSC_FEE_BIT] = flash_erase_enable;
      end else if (hit(haddr, CAUSE_IDX)) begin
        next_hrdata[CAUSE_FAULT_BIT] = flash_fault_flag;
      end else if (hit(haddr, LSTAT_IDX)) begin
        next_hrdata[7:0] = lock_byte;
        next_hrdata[LSTAT_ANY_BIT] = (lock_byte != LOCK_ERASED);
        next_hrdata[LSTAT_WR_BIT] = lock_written;
      end
    end
  end

  // program store control write, applied in the data phase
  always_comb begin
    next_flash_write_enable = flash_write_enable;
    next_flash_erase_enable = flash_erase_enable;
    if (wr_pend && hit(wr_addr, PSC_IDX)) begin
      next_flash_write_enable = hwdata[PSC_FWE_BIT];
      next_flash_erase_enable = hwdata[PSC_FEE_BIT];
    end
  end

  // lock byte latch; a safe all-locked value covers the load cycle
  always_comb begin
    next_load_pend = 1'b0;
    next_lock_byte = lock_byte;
    next_lock_written = lock_written;
    if (load_pend) begin
      next_lock_byte = lock_byte_in;
    end
    if (cpu_req && (cpu_verdict == v_allow) && (cpu_op == op_write) && (cpu_addr == LOCK_ADDR)) begin
      next_lock_written = 1'b1;
    end
    if (dbg_req && (dbg_verdict == v_allow) && (dbg_addr == LOCK_ADDR)) begin
      if (dbg_op == op_write) begin
        next_lock_written = 1'b1;
      end
    end
    if (dbg_req && (dbg_verdict == v_allow) && (dbg_op == op_dev_erase)) begin
      next_lock_byte = LOCK_ERASED;
      next_lock_written = 1'b0;
    end
  end

  // request outcomes
  always_comb begin
    fault_now = cpu_req && (cpu_verdict == v_fault);
    next_cpu_grant = cpu_req && (cpu_verdict == v_allow);
    next_cpu_refused = cpu_req && (cpu_verdict == v_refuse);
    next_dbg_grant = dbg_req && (dbg_verdict == v_allow);
    next_dbg_ignored = dbg_req && (dbg_verdict != v_allow);
    next_fault_reset_req = fault_reset_req || fault_now;
  end

  // device reset domain registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      flash_write_enable <= PSC_RESET[PSC_FWE_BIT];
      flash_erase_enable <= PSC_RESET[PSC_FEE_BIT];
      lock_byte <= LOCK_SAFE;
      load_pend <= 1'b1;
      lock_written <= 1'b0;
      cpu_grant <= 1'b0;
      cpu_refused <= 1'b0;
      dbg_grant <= 1'b0;
      dbg_ignored <= 1'b0;
      fault_reset_req <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      flash_write_enable <= next_flash_write_enable;
      flash_erase_enable <= next_flash_erase_enable;
      lock_byte <= next_lock_byte;
      load_pend <= next_load_pend;
      lock_written <= next_lock_written;
      cpu_grant <= next_cpu_grant;
      cpu_refused <= next_cpu_refused;
      dbg_grant <= next_dbg_grant;
      dbg_ignored <= next_dbg_ignored;
      fault_reset_req <= next_fault_reset_req;
    end
  end

  // reset cause: record a violation, show it from the reset that follows
  always_comb begin
    next_fault_pending = fault_pending || fault_now;
    next_flash_fault_flag = flash_fault_flag;
    if (load_pend) begin
      next_flash_fault_flag = fault_pending;
    end
    if (load_prev && !load_pend) begin
      next_fault_pending = fault_now;
    end
  end

  // power-on domain registers
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      fault_pending <= 1'b0;
      load_prev <= 1'b0;
      flash_fault_flag <= 1'b0;
    end else begin
      fault_pending <= next_fault_pending;
      load_prev <= load_pend;
      flash_fault_flag <= next_flash_fault_flag;
    end
  end
endmodule : flash_guard

// ==== test/flash_requesters.sv ====
// cpu and two-wire debug programmer model issuing flash requests
// assumes the bench calls access once per request, on the system clock
`timescale 1ns/1ps
module flash_requesters (
  input wire logic hclk, // system clock
  output logic cpu_req, // firmware request pulse
  output flash_guard_pkg::flash_op_type cpu_op, // firmware operation
  output logic [flash_guard_pkg::ADDR_W-1:0] cpu_addr, // firmware target
  output logic [flash_guard_pkg::ADDR_W-1:0] exec_addr, // executing instruction
  output logic dbg_req, // debug request pulse
  output flash_guard_pkg::flash_op_type dbg_op, // debug operation
  output logic [flash_guard_pkg::ADDR_W-1:0] dbg_addr // debug target
);
  import flash_guard_pkg::*;
  initial begin
    cpu_req = 1'b0;
    dbg_req = 1'b0;
    cpu_op = op_read;
    dbg_op = op_read;
    cpu_addr = '0;
    dbg_addr = '0;
    exec_addr = '0;
  end
  // one pulse; released address lines show the inverse so stale values never pass
  // firmware keeps interrupts off around write enable, no posts come from here
  task automatic access(input logic dbg, input flash_op_type op,
                        input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ex);
    @(posedge hclk);
    exec_addr <= ex;
    cpu_req <= !dbg;
    dbg_req <= dbg;
    cpu_op <= op;
    dbg_op <= op;
    cpu_addr <= a;
    dbg_addr <= a;
    @(posedge hclk);
    cpu_req <= 1'b0;
    dbg_req <= 1'b0;
    cpu_addr <= ~a;
    dbg_addr <= ~a;
  endtask : access
endmodule : flash_requesters

// ==== test/flash_guard_checker.sv ====
// port assertions for the flash access checker
// assumes binding onto flash_guard, a single clock domain
`timescale 1ns/1ps
module flash_guard_checker (
  input wire logic hclk, // system clock
  input wire logic hresetn, // device reset
  input wire logic cpu_req, // firmware request
  input wire flash_guard_pkg::flash_op_type cpu_op, // firmware operation
  input wire logic [flash_guard_pkg::ADDR_W-1:0] cpu_addr, // firmware target
  input wire logic cpu_grant, // firmware grant
  input wire logic cpu_refused, // firmware refusal
  input wire logic dbg_req, // debug request
  input wire logic [flash_guard_pkg::ADDR_W-1:0] dbg_addr, // debug target
  input wire logic dbg_grant, // debug grant
  input wire logic dbg_ignored, // debug drop
  input wire logic fault_reset_req, // fault reset request
  input wire logic flash_busy, // flash operation running
  input wire logic [7:0] irq_in, // interrupt posts
  input wire logic [7:0] irq_out // held interrupt lines
);
  import flash_guard_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // request and post shapes
  sequence s_dbg_res; dbg_req && dbg_addr >= RES_BASE; endsequence
  sequence s_cpu_res; cpu_req && cpu_op == op_read && cpu_addr >= RES_BASE; endsequence
  sequence s_post; !flash_busy && irq_in != 8'h00; endsequence
  AST_DBG_ONE_ANSWER: assert property (dbg_req |=> dbg_grant != dbg_ignored)
    else $error("debug request without a single answer");
  AST_DBG_NO_RESET: assert property (dbg_req && !cpu_req && !fault_reset_req |=> !fault_reset_req)
    else $error("debug request raised a fault reset");
  AST_DBG_RESERVED: assert property (s_dbg_res |=> dbg_ignored && !dbg_grant)
    else $error("debug reserved access not ignored");
  AST_CPU_RESERVED: assert property (s_cpu_res |=> fault_reset_req && !cpu_grant)
    else $error("firmware reserved read did not fault");
  AST_CPU_ANSWER: assert property (cpu_req && !fault_reset_req |=>
    $onehot({cpu_grant, cpu_refused, fault_reset_req}))
    else $error("firmware request without a single answer");
  AST_FAULT_HOLD: assert property (fault_reset_req |=> fault_reset_req)
    else $error("fault reset request dropped before reset");
  AST_FAULT_CAUSE: assert property ($rose(fault_reset_req) |-> $past(cpu_req))
    else $error("fault reset without firmware request");
  AST_NO_IDLE_GRANT: assert property (!cpu_req && !dbg_req |=> !cpu_grant && !dbg_grant)
    else $error("grant without request");
  AST_IRQ_BUSY: assert property (flash_busy && $past(flash_busy) |-> irq_out == 8'h00)
    else $error("interrupt shown during flash operation");
  AST_IRQ_POST: assert property (s_post ##1 !flash_busy |->
    (irq_out & $past(irq_in)) == $past(irq_in))
    else $error("posted interrupt not shown");
endmodule : flash_guard_checker
bind flash_guard flash_guard_checker i_flash_guard_checker (.hclk(hclk), .hresetn(hresetn),
  .cpu_req(cpu_req), .cpu_op(cpu_op), .cpu_addr(cpu_addr), .cpu_grant(cpu_grant),
  .cpu_refused(cpu_refused), .dbg_req(dbg_req), .dbg_addr(dbg_addr), .dbg_grant(dbg_grant),
  .dbg_ignored(dbg_ignored), .fault_reset_req(fault_reset_req), .flash_busy(flash_busy),
  .irq_in(irq_in), .irq_out(irq_out));

// ==== test/flash_guard_tb.sv ====
// self-checking bench for the flash access checker
// assumes the requester model and the bound checker are compiled before it
`timescale 1ns/1ps
module flash_guard_tb;
  import flash_guard_pkg::*;
  localparam logic [31:0] A_PSC = {22'h0, PSC_IDX, 2'h0};
  localparam logic [31:0] A_CAUSE = {22'h0, CAUSE_IDX, 2'h0};
  localparam logic [31:0] A_LSTAT = {22'h0, LSTAT_IDX, 2'h0};
  logic hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] lock_byte_in = 8'hff, irq_in = 8'h00, irq_ack = 8'h00, irq_out;
  logic flash_busy = 1'b0, hready, hreadyout, hresp, cpu_req, dbg_req, cpu_grant;
  logic cpu_refused, dbg_grant, dbg_ignored, fault_reset_req;
  logic [ADDR_W-1:0] exec_addr, cpu_addr, dbg_addr;
  flash_op_type cpu_op, dbg_op;
  int n_errors = 0, checks_done = 0;
  flash_op_type f_op [4] = '{op_read, op_erase, op_read, op_read};
  logic [ADDR_W-1:0] f_addr [4] = '{14'h0000, 14'h3c00, LOCK_ADDR, RES_BASE};
  logic [ADDR_W-1:0] f_ex [4] = '{14'h0400, 14'h0000, 14'h0400, 14'h0000};
  // clock and single-slave ready
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  flash_guard i_flash_guard (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .lock_byte_in(lock_byte_in), .exec_addr(exec_addr), .cpu_req(cpu_req), .cpu_op(cpu_op),
    .cpu_addr(cpu_addr), .cpu_grant(cpu_grant), .cpu_refused(cpu_refused), .dbg_req(dbg_req),
    .dbg_op(dbg_op), .dbg_addr(dbg_addr), .dbg_grant(dbg_grant), .dbg_ignored(dbg_ignored),
    .fault_reset_req(fault_reset_req), .flash_busy(flash_busy), .irq_in(irq_in),
    .irq_ack(irq_ack), .irq_out(irq_out));
  flash_requesters i_flash_requesters (.hclk(hclk), .cpu_req(cpu_req), .cpu_op(cpu_op),
    .cpu_addr(cpu_addr), .exec_addr(exec_addr), .dbg_req(dbg_req), .dbg_op(dbg_op),
    .dbg_addr(dbg_addr));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    check(what, exp, rd);
    check("response", 32'h0, {31'h0, hresp});
  endtask : rd_chk
  // verdict code: 0 grant, 1 refused or ignored, 2 fault
  task automatic req(input logic dbg, input flash_op_type op, input logic [13:0] a,
                     input logic [13:0] ex, input logic [1:0] exp);
    logic [1:0] got;
    i_flash_requesters.access(dbg, op, a, ex);
    #1;
    got = (fault_reset_req === 1'b1) ? 2'h2 :
          ((dbg ? dbg_grant : cpu_grant) === 1'b1) ? 2'h0 :
          ((dbg ? dbg_ignored : cpu_refused) === 1'b1) ? 2'h1 : 2'h3;
    check("verdict", {30'h0, exp}, {30'h0, got});
  endtask : req
  task automatic dev_reset(input logic [7:0] lock, input logic por);
    @(posedge hclk);
    hresetn <= 1'b0;
    por_n <= !por;
    lock_byte_in <= lock;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    repeat (3) @(posedge hclk);
  endtask : dev_reset
  task automatic t_regs_enables;
    rd_chk("control", A_PSC, 32'h0);
    rd_chk("unmapped", 32'h400, 32'h0);
    wr_reg(A_PSC, 32'hff);
    rd_chk("control", A_PSC, 32'h3);
    wr_reg(A_PSC, 32'h0);
    req(1'b0, op_write, 14'h0400, 14'h0600, 2'h1);
    wr_reg(A_PSC, 32'h1);
    req(1'b0, op_write, 14'h0400, 14'h0600, 2'h0);
    req(1'b0, op_erase, 14'h0400, 14'h0600, 2'h1);
    wr_reg(A_PSC, 32'h3);
    req(1'b0, op_erase, 14'h0400, 14'h0600, 2'h0);
    req(1'b1, op_read, 14'h0000, 14'h0600, 2'h0);
    $display("test regs_enables done");
  endtask : t_regs_enables
  task automatic t_locked;
    dev_reset(8'hfd, 1'b0);
    rd_chk("lock status", A_LSTAT, 32'h1fd);
    req(1'b1, op_read, 14'h0200, 14'h0400, 2'h1);
    req(1'b1, op_read, 14'h0400, 14'h0400, 2'h0);
    req(1'b1, op_read, LOCK_ADDR, 14'h0400, 2'h1);
    req(1'b1, op_write, 14'h3c00, 14'h0400, 2'h1);
    req(1'b1, op_erase, 14'h3c00, 14'h0400, 2'h1);
    req(1'b1, op_read, RES_BASE, 14'h0400, 2'h1);
    req(1'b0, op_read, 14'h0200, 14'h0000, 2'h0);
    req(1'b0, op_read, LOCK_ADDR, 14'h3c00, 2'h0);
    wr_reg(A_PSC, 32'h1);
    req(1'b0, op_write, 14'h3c00, 14'h0200, 2'h0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(A_PSC, 32'h3);
      req(1'b0, f_op[i], f_addr[i], f_ex[i], 2'h2);
      dev_reset(8'hfd, 1'b0);
      rd_chk("fault flag", A_CAUSE, 32'h1);
    end
    dev_reset(8'hfd, 1'b1);
    rd_chk("fault flag", A_CAUSE, 32'h0);
    $display("test locked done");
  endtask : t_locked
  task automatic t_lock_byte;
    dev_reset(8'hff, 1'b0);
    req(1'b1, op_erase, 14'h3c00, 14'h0400, 2'h0);
    req(1'b1, op_read, LOCK_ADDR, 14'h0400, 2'h0);
    wr_reg(A_PSC, 32'h1);
    req(1'b0, op_write, LOCK_ADDR, 14'h0400, 2'h0);
    rd_chk("lock status", A_LSTAT, 32'h2ff);
    req(1'b1, op_write, LOCK_ADDR, 14'h0400, 2'h1);
    req(1'b0, op_write, LOCK_ADDR, 14'h0400, 2'h2);
    dev_reset(8'hff, 1'b0);
    wr_reg(A_PSC, 32'h3);
    req(1'b0, op_erase, 14'h3c00, 14'h0400, 2'h2);
    dev_reset(8'hfd, 1'b0);
    req(1'b1, op_dev_erase, 14'h0000, 14'h0400, 2'h0);
    rd_chk("lock status", A_LSTAT, 32'h0ff);
    req(1'b1, op_read, 14'h0200, 14'h0400, 2'h0);
    $display("test lock_byte done");
  endtask : t_lock_byte
  task automatic t_irq;
    @(posedge hclk);
    flash_busy <= 1'b1;
    irq_in <= 8'h05;
    @(posedge hclk);
    irq_in <= 8'h00;
    @(posedge hclk);
    #1;
    check("held irq", 32'h0, {24'h0, irq_out});
    @(posedge hclk);
    flash_busy <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    check("released irq", 32'h5, {24'h0, irq_out});
    @(posedge hclk);
    irq_ack <= 8'h01;
    @(posedge hclk);
    irq_ack <= 8'h00;
    repeat (2) @(posedge hclk);
    #1;
    check("acked irq", 32'h4, {24'h0, irq_out});
    // a post while idle shows at the next edge
    @(posedge hclk);
    irq_in <= 8'h02;
    @(posedge hclk);
    irq_in <= 8'h00;
    #1;
    check("idle post irq", 32'h6, {24'h0, irq_out});
    $display("test irq done");
  endtask : t_irq
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #60000;
    n_errors++;
    end_sim;
  end
  initial begin
    dev_reset(8'hff, 1'b1);
    t_regs_enables;
    t_locked;
    t_lock_byte;
    t_irq;
    end_sim;
  end
endmodule : flash_guard_tb
